// >>> src/dps_pkg.sv
package dps_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam logic [23:0] PCT_SCALE = 24'h000064;
    // Register offsets
    localparam logic [7:0] A_WARN_LVL = 8'h00;
    localparam logic [7:0] A_WARN_TIME = 8'h04;
    localparam logic [7:0] A_TRIP_EN = 8'h08;
    localparam logic [7:0] A_TRIP_LVL = 8'h0C;
    localparam logic [7:0] A_TRIP_TIME = 8'h10;
    localparam logic [7:0] A_STALL_SEL = 8'h14;
    localparam logic [7:0] A_STALL_LVL = 8'h18;
    localparam logic [7:0] A_MO_FUNC = 8'h1C;
    localparam logic [7:0] A_RELAY_FUNC = 8'h20;
    localparam logic [7:0] A_PHASE_SEL = 8'h24;
    localparam logic [7:0] A_MOTOR_RATED = 8'h28;
    localparam logic [7:0] A_DRIVE_RATED = 8'h2C;
    localparam logic [7:0] A_REF_CRIT = 8'h30;
    localparam logic [7:0] A_REF_ACTION = 8'h34;
    localparam logic [7:0] A_REF_WAIT = 8'h38;
    localparam logic [7:0] A_DI7_FUNC = 8'h3C;
    localparam logic [7:0] A_DI8_FUNC = 8'h40;
    localparam logic [7:0] A_STATUS = 8'h44;
    localparam logic [7:0] A_FAULT = 8'h48;
    localparam logic [7:0] A_REF_MIN = 8'h4C;
    // Reset values
    localparam logic [7:0] R_WARN_LVL = 8'h96;
    localparam logic [4:0] R_WARN_TIME = 5'h0A;
    localparam logic R_TRIP_EN = 1'h1;
    localparam logic [7:0] R_TRIP_LVL = 8'hB4;
    localparam logic [5:0] R_TRIP_TIME = 6'h3C;
    localparam logic [2:0] R_STALL_SEL = 3'h0;
    localparam logic [7:0] R_STALL_LVL = 8'h96;
    localparam logic [4:0] R_MO_FUNC = 5'h0C;
    localparam logic [4:0] R_RELAY_FUNC = 5'h11;
    localparam logic [1:0] R_PHASE_SEL = 2'h0;
    localparam logic [15:0] R_RATED = 16'h03E8;
    localparam logic [1:0] R_REF_CRIT = 2'h0;
    localparam logic [1:0] R_REF_ACTION = 2'h0;
    localparam logic [10:0] R_REF_WAIT = 11'h00A;
    localparam logic [4:0] R_DI7_FUNC = 5'h06;
    localparam logic [4:0] R_DI8_FUNC = 5'h07;
    localparam logic [11:0] R_REF_MIN = 12'h000;
    // Legal setting ranges
    localparam int WARN_LVL_MIN = 30;
    localparam int WARN_LVL_MAX = 150;
    localparam int TRIP_LVL_MIN = 30;
    localparam int TRIP_LVL_MAX = 200;
    localparam int WARN_TIME_MAX = 30;
    localparam int TRIP_TIME_MAX = 60;
    localparam int OUT_FUNC_MAX = 19;
    localparam int IN_FUNC_MAX = 25;
    localparam int REF_CODE_MAX = 2;
    localparam int REF_WAIT_MIN = 1;
    localparam int REF_WAIT_MAX = 1200;
    // Function codes and field positions
    localparam int FN_OL_WARN = 5;
    localparam int FN_DRIVE_OL = 6;
    localparam int FN_STALL = 7;
    localparam int FN_REF_LOSS = 11;
    localparam int FN_FAULT = 17;
    localparam logic [4:0] DI_TRIP_NO = 5'h12;
    localparam logic [4:0] DI_TRIP_NC = 5'h13;
    localparam int SG_ACC = 0;
    localparam int SG_CONST = 1;
    localparam int SG_DEC = 2;
    localparam int PH_OUT = 0;
    localparam int PH_IN = 1;
    localparam logic [1:0] RC_HALF = 2'h1;
    localparam logic [1:0] RC_MIN = 2'h2;
    localparam logic [1:0] RA_COAST = 2'h1;
    localparam logic [1:0] RA_DECEL = 2'h2;
    localparam logic [1:0] RA_CONT = 2'h0;
    // Fault bits, also the clear mask at A_FAULT
    localparam int FB_OL_TRIP = 0;
    localparam int FB_EXT = 1;
    localparam int FB_OUT_PH = 2;
    localparam int FB_IN_PH = 3;
    localparam int FB_DRIVE_OL = 4;
    typedef enum logic [2:0] {
        REF_OK = 3'h1,
        REF_WAIT = 3'h2,
        REF_LOST = 3'h4
    } dps_ref_e;
endpackage

// >>> src/dps_level_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts ticks while armed; restarts whenever the arm condition drops
module dps_level_timer
    import dps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_arm,
    input wire logic [10:0] i_limit,
    output logic o_done
);
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    assign cnt_nxt = !i_arm ? 11'h000 :
                     (i_tick && cnt_r < i_limit) ? cnt_r + 11'h001 : cnt_r;
    assign o_done = i_arm && (cnt_r >= i_limit);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 11'h000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> src/dps_out_sel.sv
`timescale 1ns/1ps
`default_nettype none
// Multi-function terminal: picks one status flag by function code
module dps_out_sel
    import dps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [4:0] i_func,
    input wire logic [31:0] i_flags,
    output logic o_pin
);
    logic pin_nxt;
    assign pin_nxt = i_flags[i_func];
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin <= 1'h0;
        end else begin
            o_pin <= pin_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> src/dps_top.sv
// Functional notes
// [R1] Warning level is a percent of motor rating, 30 to 150, default 150.
// [R2] Warning rises after current stays above level for warn time; clears below.
// [R3] Transistor output with function 5 shows the overload warning.
// [R4] Enabled trip cuts output after current above trip level for trip time.
// [R5] Trip timer restarts when current falls back below trip level.
// [R6] Stall guard in acceleration starts deceleration on current above level.
// [R7] Stall guard at constant speed decelerates on current above level.
// [R8] Stall guard in deceleration holds the ramp while bus voltage is high.
// [R9] Stall level is a percent of motor rating, 30 to 200, default 150.
// [R10] Stall select bit 0 accel, bit 1 constant, bit 2 decel, any mix.
// [R11] Output function 7 shows stall status even with all select bits clear.
// [R12] Stall holding or reversing lets the ramp run longer than programmed.
// [R13] Phase loss select: 0 none, 1 output, 2 input, 3 both.
// [R14] Output phase loss with output protection selected cuts the output.
// [R15] Input phase loss with input protection selected blocks the output.
// [R16] Input protection without input loss cuts output when capacitor is worn.
// [R17] Input function 18 is a normally open trip: closed means fault, off.
// [R18] Input function 19 is a normally closed trip: open means fault, off.
// [R19] Current above drive rating is drive overload, shown on function 6.
// [R20] Reference loss test: 0 off, 1 below half minimum, 2 below minimum.
// [R21] After the wait: 0 keep frequency, 1 coast with output cut, 2 decel.
// [R22] Output function 11 signals reference loss to the outside sequence.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dps_top
    import dps_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic [15:0] I_MOTOR_CURRENT,
    input wire logic I_ACCEL,
    input wire logic I_CONST,
    input wire logic I_DECEL,
    input wire logic I_DC_BUS_HIGH,
    input wire logic I_OUT_PHASE_LOSS,
    input wire logic I_IN_PHASE_LOSS,
    input wire logic I_CAP_WORN,
    input wire logic I_DI7,
    input wire logic I_DI8,
    input wire logic [11:0] I_REF_LEVEL,
    output logic O_OUTPUT_OFF,
    output logic O_FAULT,
    output logic O_RAMP_DECEL,
    output logic O_RAMP_HOLD,
    output logic O_REF_HOLD_FREQ,
    output logic O_REF_DECEL_STOP,
    output logic O_MO,
    output logic O_RELAY
);
    logic [7:0] warn_lvl_r;
    logic [4:0] warn_time_r;
    logic trip_en_r;
    logic [7:0] trip_lvl_r;
    logic [5:0] trip_time_r;
    logic [2:0] stall_sel_r;
    logic [7:0] stall_lvl_r;
    logic [4:0] mo_func_r;
    logic [4:0] relay_func_r;
    logic [1:0] phase_sel_r;
    logic [15:0] motor_rated_r;
    logic [15:0] drive_rated_r;
    logic [1:0] ref_crit_r;
    logic [1:0] ref_action_r;
    logic [10:0] ref_wait_r;
    logic [4:0] di7_func_r;
    logic [4:0] di8_func_r;
    logic [11:0] ref_min_r;
    logic [4:0] fault_r;
    logic [4:0] fault_nxt;
    logic [22:0] tick_cnt_r;
    logic tick;
    dps_ref_e ref_st_r;
    dps_ref_e ref_st_nxt;

    // Register write decode; out-of-range settings are ignored
    wire wr_in = I_WR && (I_WDATA <= 32'(IN_FUNC_MAX));
    wire wr_out = I_WR && (I_WDATA <= 32'(OUT_FUNC_MAX));
    wire wr_ref = I_WR && (I_WDATA <= 32'(REF_CODE_MAX));
    wire wdata_trip_lvl = (I_WDATA >= 32'(TRIP_LVL_MIN)) && (I_WDATA <= 32'(TRIP_LVL_MAX));
    wire we_warn_lvl = I_WR && (I_ADDR == A_WARN_LVL) && (I_WDATA >= 32'(WARN_LVL_MIN))
                       && (I_WDATA <= 32'(WARN_LVL_MAX)); // R1
    wire we_warn_time = I_WR && (I_ADDR == A_WARN_TIME) && (I_WDATA <= 32'(WARN_TIME_MAX));
    wire we_trip_en = I_WR && (I_ADDR == A_TRIP_EN);
    wire we_trip_lvl = I_WR && (I_ADDR == A_TRIP_LVL) && wdata_trip_lvl; // R4
    wire we_trip_time = I_WR && (I_ADDR == A_TRIP_TIME) && (I_WDATA <= 32'(TRIP_TIME_MAX));
    wire we_stall_sel = I_WR && (I_ADDR == A_STALL_SEL) && (I_WDATA[31:3] == 29'h0);
    wire we_stall_lvl = I_WR && (I_ADDR == A_STALL_LVL) && wdata_trip_lvl; // R9
    wire we_mo_func = wr_out && (I_ADDR == A_MO_FUNC);
    wire we_relay_func = wr_out && (I_ADDR == A_RELAY_FUNC);
    wire we_phase_sel = I_WR && (I_ADDR == A_PHASE_SEL) && (I_WDATA[31:2] == 30'h0);
    wire we_motor_rated = I_WR && (I_ADDR == A_MOTOR_RATED);
    wire we_drive_rated = I_WR && (I_ADDR == A_DRIVE_RATED);
    wire we_ref_crit = wr_ref && (I_ADDR == A_REF_CRIT);
    wire we_ref_action = wr_ref && (I_ADDR == A_REF_ACTION);
    wire we_ref_wait = I_WR && (I_ADDR == A_REF_WAIT) && (I_WDATA >= 32'(REF_WAIT_MIN))
                       && (I_WDATA <= 32'(REF_WAIT_MAX));
    wire we_di7_func = wr_in && (I_ADDR == A_DI7_FUNC);
    wire we_di8_func = wr_in && (I_ADDR == A_DI8_FUNC);
    wire we_ref_min = I_WR && (I_ADDR == A_REF_MIN);
    wire we_fault = I_WR && (I_ADDR == A_FAULT);

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            warn_lvl_r <= R_WARN_LVL;
            warn_time_r <= R_WARN_TIME;
            trip_en_r <= R_TRIP_EN;
            trip_lvl_r <= R_TRIP_LVL;
            trip_time_r <= R_TRIP_TIME;
            stall_sel_r <= R_STALL_SEL;
            stall_lvl_r <= R_STALL_LVL;
            mo_func_r <= R_MO_FUNC;
            relay_func_r <= R_RELAY_FUNC;
        end else begin
            if (we_warn_lvl) warn_lvl_r <= I_WDATA[7:0];
            if (we_warn_time) warn_time_r <= I_WDATA[4:0];
            if (we_trip_en) trip_en_r <= I_WDATA[0];
            if (we_trip_lvl) trip_lvl_r <= I_WDATA[7:0];
            if (we_trip_time) trip_time_r <= I_WDATA[5:0];
            if (we_stall_sel) stall_sel_r <= I_WDATA[2:0];
            if (we_stall_lvl) stall_lvl_r <= I_WDATA[7:0];
            if (we_mo_func) mo_func_r <= I_WDATA[4:0];
            if (we_relay_func) relay_func_r <= I_WDATA[4:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            phase_sel_r <= R_PHASE_SEL;
            motor_rated_r <= R_RATED;
            drive_rated_r <= R_RATED;
            ref_crit_r <= R_REF_CRIT;
            ref_action_r <= R_REF_ACTION;
            ref_wait_r <= R_REF_WAIT;
            di7_func_r <= R_DI7_FUNC;
            di8_func_r <= R_DI8_FUNC;
            ref_min_r <= R_REF_MIN;
        end else begin
            if (we_phase_sel) phase_sel_r <= I_WDATA[1:0];
            if (we_motor_rated) motor_rated_r <= I_WDATA[15:0];
            if (we_drive_rated) drive_rated_r <= I_WDATA[15:0];
            if (we_ref_crit) ref_crit_r <= I_WDATA[1:0];
            if (we_ref_action) ref_action_r <= I_WDATA[1:0];
            if (we_ref_wait) ref_wait_r <= I_WDATA[10:0];
            if (we_di7_func) di7_func_r <= I_WDATA[4:0];
            if (we_di8_func) di8_func_r <= I_WDATA[4:0];
            if (we_ref_min) ref_min_r <= I_WDATA[11:0];
        end
    end

    // 0.1 s time base shared by all protection timers
    assign tick = (tick_cnt_r == 23'(TICK_CYCLES - 1));
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST || tick) begin
            tick_cnt_r <= 23'h000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 23'h000001;
        end
    end

    // Current against percent thresholds of motor rated current, and against drive rated current
    wire [23:0] cur_pct = 24'(I_MOTOR_CURRENT) * PCT_SCALE;
    wire over_warn = cur_pct > 24'(motor_rated_r) * 24'(warn_lvl_r); // R1
    wire over_trip = cur_pct > 24'(motor_rated_r) * 24'(trip_lvl_r); // R4
    wire over_stall = cur_pct > 24'(motor_rated_r) * 24'(stall_lvl_r); // R9
    wire drive_ol = I_MOTOR_CURRENT > drive_rated_r; // R19
    wire [10:0] warn_lim = 11'(warn_time_r) * 11'(TICKS_PER_S);
    wire [10:0] trip_lim = 11'(trip_time_r) * 11'(TICKS_PER_S);
    logic ol_warn;
    logic trip_done;
    logic ref_done;

    dps_level_timer u_warn_tmr (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_tick(tick),
        .i_arm(over_warn),
        .i_limit(warn_lim),
        .o_done(ol_warn)
    ); // R2

    dps_level_timer u_trip_tmr (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_tick(tick),
        .i_arm(over_trip),
        .i_limit(trip_lim),
        .o_done(trip_done)
    ); // R5

    // Stall guard, per ramp phase; ramp generator stretches its time
    wire stall_acc = I_ACCEL && stall_sel_r[SG_ACC] && over_stall; // R6 R10
    wire stall_const = I_CONST && stall_sel_r[SG_CONST] && over_stall; // R7 R10
    wire stall_dec = I_DECEL && stall_sel_r[SG_DEC] && I_DC_BUS_HIGH; // R8 R10
    wire stall_seen = ((I_ACCEL || I_CONST) && over_stall)
                      || (I_DECEL && I_DC_BUS_HIGH); // R11

    // Phase loss and external contacts
    wire out_ph = phase_sel_r[PH_OUT] && I_OUT_PHASE_LOSS; // R13 R14
    wire in_ph = phase_sel_r[PH_IN] && (I_IN_PHASE_LOSS || I_CAP_WORN); // R13 R15 R16
    wire ext7 = ((di7_func_r == DI_TRIP_NO) && I_DI7)
                || ((di7_func_r == DI_TRIP_NC) && !I_DI7); // R17 R18
    wire ext8 = ((di8_func_r == DI_TRIP_NO) && I_DI8)
                || ((di8_func_r == DI_TRIP_NC) && !I_DI8); // R17 R18

    // Latched faults; a new event wins over a clear in the same cycle
    wire [4:0] fault_set = {drive_ol, in_ph, out_ph, ext7 || ext8,
                            trip_en_r && trip_done}; // R4 R19
    wire [4:0] fault_clr = we_fault ? I_WDATA[4:0] : 5'h00;
    assign fault_nxt = (fault_r & ~fault_clr) | fault_set;
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            fault_r <= 5'h00;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Reference loss detection and wait
    wire [11:0] ref_half = {1'h0, ref_min_r[11:1]};
    wire ref_low = ((ref_crit_r == RC_HALF) && (I_REF_LEVEL < ref_half))
                   || ((ref_crit_r == RC_MIN) && (I_REF_LEVEL < ref_min_r)); // R20

    dps_level_timer u_ref_tmr (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_tick(tick),
        .i_arm(ref_low),
        .i_limit(ref_wait_r),
        .o_done(ref_done)
    ); // R21

    always_comb begin
        ref_st_nxt = ref_st_r;
        case (ref_st_r)
            REF_OK: begin
                if (ref_low) ref_st_nxt = REF_WAIT;
            end
            REF_WAIT: begin
                if (!ref_low) ref_st_nxt = REF_OK;
                else if (ref_done) ref_st_nxt = REF_LOST;
            end
            REF_LOST: begin
                if (!ref_low) ref_st_nxt = REF_OK;
            end
            default: ref_st_nxt = REF_OK;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            ref_st_r <= REF_OK;
        end else begin
            ref_st_r <= ref_st_nxt;
        end
    end

    wire ref_lost = (ref_st_r == REF_LOST);
    wire ref_coast = ref_lost && (ref_action_r == RA_COAST); // R21

    // Drive-side commands
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            O_OUTPUT_OFF <= 1'h0;
            O_FAULT <= 1'h0;
            O_RAMP_DECEL <= 1'h0;
            O_RAMP_HOLD <= 1'h0;
            O_REF_HOLD_FREQ <= 1'h0;
            O_REF_DECEL_STOP <= 1'h0;
        end else begin
            O_OUTPUT_OFF <= (|fault_nxt) || ref_coast; // R4 R14 R15 R16 R17 R18
            O_FAULT <= |fault_nxt; // R17 R18
            O_RAMP_DECEL <= stall_acc || stall_const; // R6 R7 R12
            O_RAMP_HOLD <= stall_dec; // R8 R12
            O_REF_HOLD_FREQ <= ref_lost && (ref_action_r == RA_CONT); // R21
            O_REF_DECEL_STOP <= ref_lost && (ref_action_r == RA_DECEL); // R21
        end
    end

    // Multi-function output terminals
    logic [31:0] flags;
    always_comb begin
        flags = 32'h00000000;
        flags[FN_OL_WARN] = ol_warn; // R3
        flags[FN_DRIVE_OL] = drive_ol || fault_r[FB_DRIVE_OL]; // R19
        flags[FN_STALL] = stall_seen; // R11
        flags[FN_REF_LOSS] = ref_lost; // R22
        flags[FN_FAULT] = |fault_r;
    end

    dps_out_sel u_mo_sel (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_func(mo_func_r),
        .i_flags(flags),
        .o_pin(O_MO)
    ); // R3

    dps_out_sel u_relay_sel (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .i_func(relay_func_r),
        .i_flags(flags),
        .o_pin(O_RELAY)
    ); // R22

    // Register read, data valid only the cycle after the strobe
    wire [31:0] status = {19'h0, fault_r, 3'h0, O_OUTPUT_OFF, drive_ol,
                          ref_lost, stall_seen, ol_warn};
    wire [31:0] rd_mux =
        (I_ADDR == A_WARN_LVL) ? 32'(warn_lvl_r) :
        (I_ADDR == A_WARN_TIME) ? 32'(warn_time_r) :
        (I_ADDR == A_TRIP_EN) ? 32'(trip_en_r) :
        (I_ADDR == A_TRIP_LVL) ? 32'(trip_lvl_r) :
        (I_ADDR == A_TRIP_TIME) ? 32'(trip_time_r) :
        (I_ADDR == A_STALL_SEL) ? 32'(stall_sel_r) :
        (I_ADDR == A_STALL_LVL) ? 32'(stall_lvl_r) :
        (I_ADDR == A_MO_FUNC) ? 32'(mo_func_r) :
        (I_ADDR == A_RELAY_FUNC) ? 32'(relay_func_r) :
        (I_ADDR == A_PHASE_SEL) ? 32'(phase_sel_r) :
        (I_ADDR == A_MOTOR_RATED) ? 32'(motor_rated_r) :
        (I_ADDR == A_DRIVE_RATED) ? 32'(drive_rated_r) :
        (I_ADDR == A_REF_CRIT) ? 32'(ref_crit_r) :
        (I_ADDR == A_REF_ACTION) ? 32'(ref_action_r) :
        (I_ADDR == A_REF_WAIT) ? 32'(ref_wait_r) :
        (I_ADDR == A_DI7_FUNC) ? 32'(di7_func_r) :
        (I_ADDR == A_DI8_FUNC) ? 32'(di8_func_r) :
        (I_ADDR == A_STATUS) ? status :
        (I_ADDR == A_FAULT) ? 32'(fault_r) :
        (I_ADDR == A_REF_MIN) ? 32'(ref_min_r) : 32'h00000000;

    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            O_RDATA <= 32'h00000000;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 32'h00000000;
        end
    end

    // Checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    property p_warn_pin;
        (mo_func_r == 5'(FN_OL_WARN)) && $stable(mo_func_r) |=> O_MO == $past(ol_warn);
    endproperty
    a_warn_pin: assert property (p_warn_pin) else $error("MO not following warning"); // R3

    property p_warn_clear;
        !over_warn && (mo_func_r == 5'(FN_OL_WARN)) |=> !O_MO;
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning held below level"); // R2

    property p_trip_cut;
        trip_en_r && trip_done |=> O_OUTPUT_OFF && O_FAULT;
    endproperty
    a_trip_cut: assert property (p_trip_cut) else $error("trip did not cut output"); // R4

    property p_trip_restart;
        (trip_lim != 11'h000) && $rose(over_trip) |-> !trip_done;
    endproperty
    a_trip_restart: assert property (p_trip_restart) else $error("trip timer kept"); // R5

    property p_stall_acc;
        I_ACCEL && stall_sel_r[SG_ACC] && over_stall |=> O_RAMP_DECEL;
    endproperty
    a_stall_acc: assert property (p_stall_acc) else $error("no stall decel"); // R6

    property p_stall_hold;
        O_RAMP_HOLD |-> $past(stall_sel_r[SG_DEC] && I_DECEL && I_DC_BUS_HIGH);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("ramp hold without cause"); // R8

    property p_stall_seen;
        (stall_sel_r == 3'h0) && (mo_func_r == 5'(FN_STALL)) && I_DECEL && I_DC_BUS_HIGH
            |=> O_MO && !O_RAMP_HOLD;
    endproperty
    a_stall_seen: assert property (p_stall_seen) else $error("stall status missing"); // R11

    property p_out_phase;
        phase_sel_r[PH_OUT] && I_OUT_PHASE_LOSS
            |=> O_OUTPUT_OFF ##1 (O_OUTPUT_OFF || $past(we_fault));
    endproperty
    a_out_phase: assert property (p_out_phase) else $error("output phase loss ignored"); // R14

    property p_ext_no;
        (di7_func_r == DI_TRIP_NO) && I_DI7 |=> O_FAULT && O_OUTPUT_OFF;
    endproperty
    a_ext_no: assert property (p_ext_no) else $error("open contact trip ignored"); // R17

    property p_ext_nc;
        (di8_func_r == DI_TRIP_NC) && !I_DI8 |=> O_FAULT && O_OUTPUT_OFF;
    endproperty
    a_ext_nc: assert property (p_ext_nc) else $error("closed contact trip ignored"); // R18

    property p_ref_off;
        (ref_crit_r == R_REF_CRIT) [*2] |-> !ref_lost;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("loss seen while disabled"); // R20

    property p_ref_coast;
        ref_lost && (ref_action_r == RA_COAST) |=> O_OUTPUT_OFF;
    endproperty
    a_ref_coast: assert property (p_ref_coast) else $error("coast did not cut"); // R21

    c_warn: cover property (ol_warn && O_MO);
    c_trip: cover property (trip_en_r && trip_done ##1 O_OUTPUT_OFF);
    c_ref_lost: cover property (ref_st_r == REF_WAIT ##1 ref_lost);
    c_ext: cover property ($rose(O_FAULT) && fault_r[FB_EXT]);
endmodule
`default_nettype wire

// >>> sim/dps_field_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: trip contacts and current sensor; the break contact idles closed
module dps_field_model (
    input wire logic i_clk,
    input wire logic i_trip_a,
    input wire logic i_trip_b,
    input wire logic [15:0] i_amps,
    output logic o_di7,
    output logic o_di8,
    output logic [15:0] o_current
);
    always_ff @(posedge i_clk) begin
        o_di7 <= i_trip_a;
        o_di8 <= !i_trip_b;
        o_current <= i_amps;
    end
endmodule
`default_nettype wire

// >>> sim/drive_protection_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module drive_protection_supervisor_tb_top;
    import dps_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ta = 1'b0, tb = 1'b0;
    logic bus_hi = 1'b0, opl = 1'b0, ipl = 1'b0, cap = 1'b0, di7, di8;
    logic [2:0] ph = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] amps = 16'h0000, cur;
    logic [11:0] ref_lvl = 12'h800;
    logic off, flt, rdec, rhold, hfreq, dstop, mo, rel;
    int fail_count = 0, n_compared = 0;
    initial forever #10 clk = ~clk;
    dps_field_model field (.i_clk(clk), .i_trip_a(ta), .i_trip_b(tb), .i_amps(amps),
        .o_di7(di7), .o_di8(di8), .o_current(cur));
    dps_top #(.TICK_CYCLES(10)) dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_MOTOR_CURRENT(cur),
        .I_ACCEL(ph[0]), .I_CONST(ph[1]), .I_DECEL(ph[2]), .I_DC_BUS_HIGH(bus_hi),
        .I_OUT_PHASE_LOSS(opl), .I_IN_PHASE_LOSS(ipl), .I_CAP_WORN(cap), .I_DI7(di7),
        .I_DI8(di8), .I_REF_LEVEL(ref_lvl), .O_OUTPUT_OFF(off), .O_FAULT(flt),
        .O_RAMP_DECEL(rdec), .O_RAMP_HOLD(rhold), .O_REF_HOLD_FREQ(hfreq),
        .O_REF_DECEL_STOP(dstop), .O_MO(mo), .O_RELAY(rel));
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(A_WARN_LVL, 32'h96);
        rchk(A_TRIP_LVL, 32'hB4);
        rchk(A_STALL_LVL, 32'h96);
        wreg(A_WARN_LVL, 32'h97);
        rchk(A_WARN_LVL, 32'h96);
        wreg(A_DRIVE_RATED, 32'h7D0);
        wreg(A_MO_FUNC, 32'(FN_STALL));
        amps <= 16'h05DD;
        for (int b = 0; b < 3; b++) begin
            wreg(A_STALL_SEL, 32'(1 << b));
            ph <= 3'(1 << b);
            bus_hi <= (b == 2);
            cyc(5);
            check(rdec, (b < 2));
            check(rhold, (b == 2));
            check(mo, 1);
        end
        wreg(A_STALL_SEL, 32'h0);
        cyc(4);
        check(rhold, 0);
        check(mo, 1);
        wreg(A_WARN_LVL, 32'h64);
        wreg(A_WARN_TIME, 32'h1);
        amps <= 16'h0000;
        wreg(A_MO_FUNC, 32'(FN_OL_WARN));
        amps <= 16'h05DD;
        ph <= 3'h0;
        bus_hi <= 1'b0;
        cyc(60);
        check(mo, 0);
        cyc(70);
        check(mo, 1);
        wreg(A_DI7_FUNC, {27'h0, DI_TRIP_NO});
        amps <= 16'h0000;
        ta <= 1'b1;
        cyc(5);
        check(mo, 0);
        check({off, flt}, 2'h3);
        wreg(A_DI8_FUNC, {27'h0, DI_TRIP_NC});
        ta <= 1'b0;
        tb <= 1'b1;
        wreg(A_FAULT, 32'h2);
        cyc(4);
        check({off, flt}, 2'h3);
        wreg(A_PHASE_SEL, 32'h1);
        tb <= 1'b0;
        wreg(A_FAULT, 32'h2);
        cyc(4);
        check({off, flt}, 2'h0);
        @(posedge clk) ipl <= 1'b1;
        cyc(4);
        check(off, 0);
        @(posedge clk) opl <= 1'b1;
        cyc(4);
        check(off, 1);
        wreg(A_PHASE_SEL, 32'h2);
        opl <= 1'b0;
        ipl <= 1'b0;
        wreg(A_FAULT, 32'h1F);
        cap <= 1'b1;
        cyc(4);
        check(off, 1);
        wreg(A_RELAY_FUNC, 32'(FN_DRIVE_OL));
        amps <= 16'h07D1;
        cyc(5);
        check(rel, 1);
        wreg(A_TRIP_TIME, 32'h1);
        amps <= 16'h0000;
        cap <= 1'b0;
        wreg(A_FAULT, 32'h1F);
        amps <= 16'h0709;
        cyc(60);
        check(flt, 0);
        wreg(A_REF_MIN, 32'h400);
        amps <= 16'h0000;
        wreg(A_REF_WAIT, 32'h2);
        amps <= 16'h0709;
        cyc(60);
        check(flt, 0);
        cyc(60);
        check({off, flt}, 2'h3);
        wreg(A_RELAY_FUNC, 32'(FN_REF_LOSS));
        amps <= 16'h0000;
        wreg(A_FAULT, 32'h1F);
        wreg(A_REF_CRIT, 32'h1);
        ref_lvl <= 12'h3FF;
        cyc(40);
        check({rel, hfreq}, 2'h0);
        wreg(A_REF_CRIT, 32'h2);
        cyc(5);
        check({rel, hfreq}, 2'h0);
        cyc(40);
        check({rel, hfreq}, 2'h3);
        wreg(A_REF_ACTION, 32'h2);
        cyc(2);
        check({off, dstop, hfreq}, 3'h2);
        wreg(A_REF_ACTION, 32'h1);
        cyc(2);
        check({off, dstop}, 2'h2);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
